// ---- hdl/ims_params.svh ----
// Constants for the indexed-mode bus cycle sequencer
`ifndef IMS_PARAMS_SVH
`define IMS_PARAMS_SVH

// ****************************************
// Bus timing
// ****************************************
`define IMS_CLK_PERIOD_NS  100
`define IMS_BUS_CYCLE_NS   1000
`define IMS_BUS_CYCLE_CLKS (`IMS_BUS_CYCLE_NS / `IMS_CLK_PERIOD_NS)

// ****************************************
// Addresses and line levels
// ****************************************
`define IMS_DUMMY_ADDR     16'hFFFF
`define IMS_RW_READ        1'b1
`define IMS_RW_WRITE       1'b0
`define IMS_RET_STEP       16'h0002
`define IMS_ADDR_STEP      16'h0001

// ****************************************
// Instruction lengths in bus cycles
// ****************************************
`define IMS_LEN_JUMP       3'h3
`define IMS_LEN_SHORT      3'h4
`define IMS_LEN_WORD       3'h5
`define IMS_LEN_LONG       3'h6

`endif

// ---- hdl/ims_pkg.sv ----
// Types shared by the indexed-mode bus cycle sequencer
`default_nettype none

package ims_pkg;

    // ****************************************
    // Instruction groups given by the decoder
    // ****************************************
    typedef enum logic [3:0] {
        GRP_JUMP,
        GRP_ALU,
        GRP_STORE_ACC,
        GRP_LOAD16,
        GRP_STORE16,
        GRP_RMW,
        GRP_TEST,
        GRP_ARITH16,
        GRP_CALL
    } ims_group_type;

    // ****************************************
    // Meaning of the data byte in a bus cycle
    // ****************************************
    typedef enum logic [3:0] {
        K_OPCODE,
        K_OFFSET,
        K_DUMMY,
        K_OPERAND,
        K_OPND_HI,
        K_OPND_LO,
        K_SUB_OPCODE,
        K_WR_BYTE,
        K_WR_HI,
        K_WR_LO,
        K_WR_NEW,
        K_RET_LO,
        K_RET_HI
    } ims_kind_type;

    typedef struct packed {
        logic [15:0] opcode_addr;
        logic [15:0] index_reg;
        logic [15:0] stack_ptr;
        logic [15:0] store_word;
    } ims_req_type;

    typedef struct packed {
        logic [15:0] address_lines;
        logic        rw;
        logic [7:0]  data_out;
        logic        data_oe_n;
    } ims_bus_type;

    typedef struct packed {
        logic         valid;
        ims_kind_type kind;
        logic [7:0]   data;
    } ims_read_type;

endpackage : ims_pkg

`default_nettype wire

// ---- hdl/ims_cycle_map.sv ----
// Per-cycle address, line level and data meaning for each group
`include "ims_params.svh"
`default_nettype none

module ims_cycle_map (
    input  wire ims_pkg::ims_group_type group,
    input  wire logic [2:0]             cycle,
    input  wire logic [15:0]            opcode_addr,
    input  wire logic [15:0]            eff_addr,
    input  wire logic [15:0]            stack_ptr,
    output var  logic [15:0]            addr,
    output var  logic                   rw,
    output var  ims_pkg::ims_kind_type  kind,
    output var  logic [2:0]             len
);
    import ims_pkg::*;

    always_comb begin
        case (group)
            GRP_JUMP:                        len = `IMS_LEN_JUMP;    // see RULE1
            GRP_ALU, GRP_STORE_ACC:          len = `IMS_LEN_SHORT;   // see RULE2
            GRP_LOAD16, GRP_STORE16:         len = `IMS_LEN_WORD;    // see RULE3 see RULE4
            default:                         len = `IMS_LEN_LONG;    // see RULE5 see RULE7 see RULE8
        endcase
    end

    always_comb begin
        addr = `IMS_DUMMY_ADDR;
        rw   = `IMS_RW_READ;
        kind = K_DUMMY;
        case (cycle)
            3'h1: begin
                addr = opcode_addr;                                  // see RULE1
                kind = K_OPCODE;
            end
            3'h2: begin
                addr = opcode_addr + `IMS_ADDR_STEP;                 // see RULE1
                kind = K_OFFSET;
            end
            3'h3: begin
                kind = K_DUMMY;                                      // see RULE1
            end
            3'h4: begin
                addr = eff_addr;
                case (group)
                    GRP_ALU:       kind = K_OPERAND;                 // see RULE2
                    GRP_STORE_ACC: begin
                        rw   = `IMS_RW_WRITE;                        // see RULE2
                        kind = K_WR_BYTE;
                    end
                    GRP_LOAD16, GRP_ARITH16: kind = K_OPND_HI;       // see RULE3 see RULE7
                    GRP_STORE16: begin
                        rw   = `IMS_RW_WRITE;                        // see RULE4
                        kind = K_WR_HI;
                    end
                    GRP_RMW, GRP_TEST: kind = K_OPERAND;             // see RULE5
                    GRP_CALL:      kind = K_SUB_OPCODE;              // see RULE8
                    default:       kind = K_DUMMY;
                endcase
            end
            3'h5: begin
                case (group)
                    GRP_LOAD16, GRP_ARITH16: begin
                        addr = eff_addr + `IMS_ADDR_STEP;            // see RULE3 see RULE7
                        kind = K_OPND_LO;
                    end
                    GRP_STORE16: begin
                        addr = eff_addr + `IMS_ADDR_STEP;            // see RULE4
                        rw   = `IMS_RW_WRITE;
                        kind = K_WR_LO;
                    end
                    GRP_CALL: begin
                        addr = stack_ptr;                            // see RULE9
                        rw   = `IMS_RW_WRITE;
                        kind = K_RET_LO;
                    end
                    default: kind = K_DUMMY;                         // see RULE5
                endcase
            end
            3'h6: begin
                case (group)
                    GRP_RMW: begin
                        addr = eff_addr;                             // see RULE5
                        rw   = `IMS_RW_WRITE;
                        kind = K_WR_NEW;
                    end
                    GRP_CALL: begin
                        addr = stack_ptr - `IMS_ADDR_STEP;           // see RULE10
                        rw   = `IMS_RW_WRITE;
                        kind = K_RET_HI;
                    end
                    default: kind = K_DUMMY;                         // see RULE6 see RULE7
                endcase
            end
            default: kind = K_DUMMY;
        endcase
    end

endmodule // ims_cycle_map

`default_nettype wire

// ---- hdl/ims_sequencer.sv ----
// Bus cycle sequencer for indexed-mode instructions
//
// Contract
// RULE1 - Opcode, offset, dummy FFFF; jump ends there
// RULE2 - Byte ops read, accumulator store writes, cycle four
// RULE3 - Word loads read high then low byte
// RULE4 - Word stores write high then low, line low
// RULE5 - Read-modify-write: read, dummy FFFF, write back
// RULE6 - Test instruction sixth cycle reads FFFF, no write
// RULE7 - Word compare/add/subtract: high, low, dummy FFFF
// RULE8 - Call reads subroutine opcode in cycle four
// RULE9 - Call writes return low byte at stack
// RULE10 - Call writes return high byte at stack-1
// RULE11 - Line high when reading; dummy data discarded
`include "ims_params.svh"
`default_nettype none

module ims_sequencer #(
    parameter int BUS_CLKS = `IMS_BUS_CYCLE_CLKS
) (
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire logic                   start,
    input  wire ims_pkg::ims_req_type   req_in,
    input  wire ims_pkg::ims_group_type group_in,
    input  wire logic [7:0]             new_operand,
    input  wire logic [7:0]             data_in,
    output var  ims_pkg::ims_bus_type   bus_q,
    output var  ims_pkg::ims_read_type  rd_q,
    output var  logic [7:0]             opcode_q,
    output var  logic [15:0]            ea_q,
    output var  logic [2:0]             cycle_q,
    output var  logic                   busy_q,
    output var  logic                   done_q
);
    import ims_pkg::*;

    localparam int PW = (BUS_CLKS > 1) ? $clog2(BUS_CLKS) : 1;
    localparam logic [PW-1:0] PHASE_LAST = PW'(BUS_CLKS - 1);

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_RUN
    } ims_state_type;

    // ****************************************
    // Registers
    // ****************************************
    ims_state_type  state_q;
    logic [PW-1:0]  phase_q;
    ims_req_type    req_q;
    ims_group_type  group_q;
    ims_kind_type   kind_q;
    logic [7:0]     din_meta_q;
    logic [7:0]     din_sync_q;

    // ****************************************
    // Combinational terms
    // ****************************************
    logic           end_of_cycle;
    logic           finish;
    logic           load_next;
    logic [2:0]     map_cycle;
    ims_group_type  map_group;
    logic [15:0]    map_opaddr;
    logic [15:0]    map_stack;
    logic [15:0]    map_addr;
    logic           map_rw;
    ims_kind_type   map_kind;
    logic [2:0]     map_len;
    logic [15:0]    ret_addr;
    logic [7:0]     wr_byte;
    logic           is_read_kind;

    // ****************************************
    // Data line synchroniser
    // ****************************************
    // Pins are asynchronous to core_clk; the bus cycle spans many clocks
    // so the two-clock latency is hidden inside the cycle.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            din_meta_q <= 8'h00;
            din_sync_q <= 8'h00;
        end else begin
            din_meta_q <= data_in;
            din_sync_q <= din_meta_q;
        end
    end

    // ****************************************
    // Cycle map lookup for the next bus cycle
    // ****************************************
    assign end_of_cycle = (state_q == ST_RUN) && (phase_q == PHASE_LAST);
    // Group is not known before cycle two ends; cycle three is common
    assign map_group    = (cycle_q == 3'h2) ? group_in : group_q;
    assign finish       = end_of_cycle && (cycle_q == map_len);          // see RULE1
    assign load_next    = (state_q == ST_IDLE) ? start : (end_of_cycle && !finish);
    assign map_cycle    = (state_q == ST_IDLE) ? 3'h1 : cycle_q + 3'h1;
    assign map_opaddr   = (state_q == ST_IDLE) ? req_in.opcode_addr : req_q.opcode_addr;
    assign map_stack    = req_q.stack_ptr;
    assign ret_addr     = req_q.opcode_addr + `IMS_RET_STEP;

    ims_cycle_map u_map (
        .group       (map_group),
        .cycle       (map_cycle),
        .opcode_addr (map_opaddr),
        .eff_addr    (ea_q),
        .stack_ptr   (map_stack),
        .addr        (map_addr),
        .rw          (map_rw),
        .kind        (map_kind),
        .len         (map_len)
    );

    always_comb begin
        case (map_kind)
            K_WR_BYTE: wr_byte = req_q.store_word[7:0];                  // see RULE2
            K_WR_HI:   wr_byte = req_q.store_word[15:8];                 // see RULE4
            K_WR_LO:   wr_byte = req_q.store_word[7:0];                  // see RULE4
            K_WR_NEW:  wr_byte = new_operand;                            // see RULE5
            K_RET_LO:  wr_byte = ret_addr[7:0];                          // see RULE9
            K_RET_HI:  wr_byte = ret_addr[15:8];                         // see RULE10
            default:   wr_byte = 8'h00;
        endcase
    end

    always_comb begin
        case (kind_q)
            K_OPCODE, K_OFFSET, K_OPERAND, K_OPND_HI,
            K_OPND_LO, K_SUB_OPCODE: is_read_kind = 1'b1;
            default:                 is_read_kind = 1'b0;               // see RULE11
        endcase
    end

    // ****************************************
    // Sequencing state
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
        end else if (state_q == ST_IDLE && start) begin
            state_q <= ST_RUN;
        end else if (finish) begin
            state_q <= ST_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            phase_q <= '0;
        end else if (state_q != ST_RUN || phase_q == PHASE_LAST) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_q + PW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cycle_q <= 3'h0;
        end else if (load_next) begin
            cycle_q <= map_cycle;
        end else if (finish) begin
            cycle_q <= 3'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            req_q <= '0;
        end else if (state_q == ST_IDLE && start) begin
            req_q <= req_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            group_q <= GRP_JUMP;
        end else if (end_of_cycle && cycle_q == 3'h2) begin
            group_q <= group_in;
        end
    end

    // ****************************************
    // Captured opcode and effective address
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            opcode_q <= 8'h00;
        end else if (end_of_cycle && kind_q == K_OPCODE) begin
            opcode_q <= din_sync_q;                                      // see RULE1
        end
    end

    // Offset is unsigned; the sum wraps inside the 64k map
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ea_q <= 16'h0000;
        end else if (end_of_cycle && kind_q == K_OFFSET) begin
            ea_q <= req_q.index_reg + {8'h00, din_sync_q};               // see RULE2
        end
    end

    // ****************************************
    // Bus drive
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bus_q.address_lines <= `IMS_DUMMY_ADDR;
            bus_q.rw            <= `IMS_RW_READ;
            bus_q.data_out      <= 8'h00;
            bus_q.data_oe_n     <= 1'b1;
            kind_q              <= K_DUMMY;
        end else if (load_next) begin
            bus_q.address_lines <= map_addr;
            bus_q.rw            <= map_rw;                               // see RULE11
            bus_q.data_out      <= wr_byte;
            bus_q.data_oe_n     <= map_rw;                               // see RULE11
            kind_q              <= map_kind;
        end else if (finish) begin
            // Release the data lines between instructions
            bus_q.rw            <= `IMS_RW_READ;
            bus_q.data_oe_n     <= 1'b1;
            kind_q              <= K_DUMMY;
        end
    end

    // ****************************************
    // Read data hand-off to the core
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_q <= '0;
        end else if (end_of_cycle && is_read_kind) begin
            rd_q.valid <= 1'b1;
            rd_q.kind  <= kind_q;
            rd_q.data  <= din_sync_q;
        end else begin
            // Dummy cycles at FFFF never raise valid
            rd_q.valid <= 1'b0;                                          // see RULE6 see RULE11
        end
    end

    // ****************************************
    // Status
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            busy_q <= 1'b0;
        end else if (state_q == ST_IDLE && start) begin
            busy_q <= 1'b1;
        end else if (finish) begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            done_q <= 1'b0;
        end else begin
            done_q <= finish;
        end
    end

endmodule // ims_sequencer

`default_nettype wire

// ---- verif/ims_seq_props.sv ----
// Port-level checker for the indexed-mode bus cycle sequencer
`default_nettype none

module ims_seq_props #(
    parameter int BUS_CLKS = 10
) (
    input wire logic                   core_clk,
    input wire logic                   reset,
    input wire logic                   start,
    input wire ims_pkg::ims_req_type   req_in,
    input wire ims_pkg::ims_group_type group_in,
    input wire logic [7:0]             new_operand,
    input wire logic [7:0]             data_in,
    input wire ims_pkg::ims_bus_type   bus_q,
    input wire ims_pkg::ims_read_type  rd_q,
    input wire logic [7:0]             opcode_q,
    input wire logic [15:0]            ea_q,
    input wire logic [2:0]             cycle_q,
    input wire logic                   busy_q,
    input wire logic                   done_q
);
    timeunit 1ns;
    timeprecision 1ns;
    import ims_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    logic [15:0] oa_q;
    logic [15:0] sp_q;
    logic [15:0] ret_q;
    logic [2:0]  cyc_q;
    int          stay_q;

    always_ff @(posedge core_clk) begin
        if (start && !busy_q) begin
            oa_q  <= req_in.opcode_addr;
            sp_q  <= req_in.stack_ptr;
            ret_q <= req_in.opcode_addr + 16'h0002;
        end
    end

    // Counts edges a cycle number has stood, to judge bus cycle length
    always_ff @(posedge core_clk) begin
        cyc_q  <= reset ? 3'h0 : cycle_q;
        stay_q <= (cycle_q != cyc_q) ? 0 : stay_q + 1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // ****************************************
    // Properties
    // ****************************************
    sequence call_lo_s;
        cycle_q == 3'h5 && !bus_q.rw && bus_q.address_lines == sp_q
            && bus_q.address_lines != ea_q + 16'h0001;
    endsequence
    sequence ret_hi_s;
        cycle_q == 3'h6 && !bus_q.rw && bus_q.address_lines == sp_q - 16'h0001
            && bus_q.data_out == ret_q[15:8];
    endsequence

    oe_follows_rw_a: assert property (bus_q.data_oe_n == bus_q.rw)
        else $error("data enable differs from line level");
    fetch_on_start_a: assert property (start && !busy_q |=> cycle_q == 3'h1 && bus_q.rw
        && bus_q.address_lines == $past(req_in.opcode_addr)) else $error("bad opcode fetch");
    offset_next_a: assert property (cycle_q == 3'h2 |-> bus_q.rw
        && bus_q.address_lines == oa_q + 16'h0001) else $error("bad offset read");
    dummy_third_a: assert property (cycle_q == 3'h3 |-> bus_q.rw
        && bus_q.address_lines == 16'hFFFF) else $error("bad third cycle");
    operand_at_ea_a: assert property (cycle_q == 3'h4 |-> bus_q.address_lines == ea_q)
        else $error("fourth cycle not at index plus offset");
    sixth_dummy_a: assert property (cycle_q == 3'h6 && bus_q.rw
        |-> bus_q.address_lines == 16'hFFFF) else $error("sixth cycle read not dummy");
    read_pulse_a: assert property (rd_q.valid |-> $past(bus_q.rw)
        && rd_q.kind != K_DUMMY && rd_q.kind < K_WR_BYTE) else $error("bad read pulse");
    late_writes_a: assert property (!bus_q.rw |-> cycle_q >= 3'h4)
        else $error("write in an early cycle");
    cycle_length_a: assert property (cycle_q != cyc_q && cyc_q != 3'h0 && cycle_q != 3'h0
        |-> stay_q == BUS_CLKS - 1) else $error("bus cycle length wrong");
    return_push_a: assert property (call_lo_s |-> bus_q.data_out == ret_q[7:0]
        ##BUS_CLKS ret_hi_s) else $error("return address push wrong");

endmodule // ims_seq_props

`default_nettype wire

// ---- verif/ims_bus_memory.sv ----
// Memory and peripheral model on the far side of the sequencer bus
`default_nettype none

module ims_bus_memory (
    input  wire logic                 core_clk,
    input  wire logic                 slow,
    input  wire ims_pkg::ims_bus_type bus,
    output var  logic [7:0]           data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import ims_pkg::*;

    logic [15:0] addr_q = 16'h0000;
    logic [7:0]  last_q = 8'h00;
    logic        late;

    always @(posedge core_clk) begin
        addr_q <= bus.address_lines;
        last_q <= data_in;
    end

    // Slow mode answers one clock after the address moves, the latest allowed
    assign late = slow && (addr_q != bus.address_lines);
    // Lines not driven by memory show a changing wrong value, not a held one
    assign data_in = (bus.rw && !late) ?
        (bus.address_lines[7:0] ^ bus.address_lines[15:8] ^ 8'h3C) : ~last_q;

endmodule // ims_bus_memory

`default_nettype wire

// ---- verif/indexed_mode_bus_cycle_sequencer_test.sv ----
// Self-checking bench for the indexed-mode bus cycle sequencer
`default_nettype none

module indexed_mode_bus_cycle_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ims_pkg::*;

    localparam int BC = 4;
    logic          core_clk = 1'b0;
    logic          reset    = 1'b1;
    logic          start    = 1'b0;
    logic          slow     = 1'b0;
    ims_req_type   req      = '0;
    ims_group_type grp      = GRP_JUMP;
    logic [7:0]    new_op   = 8'h00;
    logic [7:0]    data_in;
    ims_bus_type   bus_q;
    ims_read_type  rd_q;
    logic [7:0]    opcode_q;
    logic [15:0]   ea_q;
    logic [2:0]    cycle_q;
    logic          busy_q;
    logic          done_q;
    int            miscompares  = 0;
    int            total_checks = 0;
    int            ticks        = 0;
    int            dones        = 0;
    logic [7:0]    rd_d[$];

    ims_sequencer #(.BUS_CLKS(BC)) ims_sequencer_inst (.core_clk(core_clk), .reset(reset),
        .start(start), .req_in(req), .group_in(grp), .new_operand(new_op), .data_in(data_in),
        .bus_q(bus_q), .rd_q(rd_q), .opcode_q(opcode_q), .ea_q(ea_q), .cycle_q(cycle_q),
        .busy_q(busy_q), .done_q(done_q));
    ims_bus_memory ims_bus_memory_inst (.core_clk(core_clk), .slow(slow), .bus(bus_q),
        .data_in(data_in));

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    // ****************************************
    // Logging, timeout and reporting
    // ****************************************
    always @(posedge core_clk) begin
        if (rd_q.valid === 1'b1)
            rd_d.push_back(rd_q.data);
        if (done_q === 1'b1)
            dones++;
        ticks++;
        if (ticks == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    function automatic logic [7:0] mem_val(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction

    // Returns {dummy, address, line level, write data} for one bus cycle
    function automatic logic [25:0] expc(input ims_group_type g, input int n,
        input logic [15:0] oa, ea, sp, sw, input logic [7:0] nv);
        logic [15:0] r;
        r = oa + 16'h0002;
        case (n)
            1: return {1'b0, oa, 1'b1, 8'h00};
            2: return {1'b0, oa + 16'h0001, 1'b1, 8'h00};
            3: return {1'b1, 16'hFFFF, 1'b1, 8'h00};
            4: return (g == GRP_STORE_ACC) ? {1'b0, ea, 1'b0, sw[7:0]} :
                (g == GRP_STORE16) ? {1'b0, ea, 1'b0, sw[15:8]} : {1'b0, ea, 1'b1, 8'h00};
            5: return (g == GRP_STORE16) ? {1'b0, ea + 16'h0001, 1'b0, sw[7:0]} :
                (g == GRP_CALL) ? {1'b0, sp, 1'b0, r[7:0]} :
                (g == GRP_RMW || g == GRP_TEST) ? {1'b1, 16'hFFFF, 1'b1, 8'h00} :
                {1'b0, ea + 16'h0001, 1'b1, 8'h00};
            default: return (g == GRP_RMW) ? {1'b0, ea, 1'b0, nv} :
                (g == GRP_CALL) ? {1'b0, sp - 16'h0001, 1'b0, r[15:8]} :
                {1'b1, 16'hFFFF, 1'b1, 8'h00};
        endcase
    endfunction

    // ****************************************
    // One instruction, checked cycle by cycle
    // ****************************************
    task automatic run_op(input ims_group_type g, input logic [15:0] oa, ix);
        int          len;
        logic [25:0] e;
        logic [15:0] ea;
        logic [7:0]  ed[$];
        len = (g == GRP_JUMP) ? 3 : (g <= GRP_STORE_ACC) ? 4 : (g <= GRP_STORE16) ? 5 : 6;
        ea = ix + {8'h00, mem_val(oa + 16'h0001)};
        rd_d.delete();
        dones = 0;
        grp <= g;
        new_op <= 8'hC3;
        slow <= g[0];
        req <= '{oa, ix, 16'h0400, 16'hA55A};
        start <= 1'b1;
        @(posedge core_clk) start <= 1'b0;
        for (int n = 1; n <= len; n++) begin
            e = expc(g, n, oa, ea, 16'h0400, 16'hA55A, 8'hC3);
            repeat (2) @(posedge core_clk);
            #1;
            check(bus_q.address_lines === e[24:9] && bus_q.rw === e[8]
                && cycle_q === n[2:0], "address or line level");
            check(bus_q.data_oe_n === e[8] && (e[8] || bus_q.data_out === e[7:0]), "write data");
            if (e[8] && !e[25])
                ed.push_back(mem_val(e[24:9]));
            repeat (BC - 2) @(posedge core_clk);
        end
        repeat (3) @(posedge core_clk);
        check(busy_q === 1'b0 && dones == 1, "instruction end");
        check(opcode_q === mem_val(oa) && ea_q === ea, "opcode or address");
        check(rd_d.size() == ed.size() && rd_d == ed, "read data");
        $display("test %s ended", g.name());
    endtask

    task automatic test_jump;
        run_op(GRP_JUMP, 16'h1000, 16'h0200);
    endtask
    // Index near the top so the operand address wraps
    task automatic test_alu;
        run_op(GRP_ALU, 16'h2000, 16'hFFF0);
    endtask
    task automatic test_store_acc;
        run_op(GRP_STORE_ACC, 16'h2100, 16'h0300);
    endtask
    task automatic test_load16;
        run_op(GRP_LOAD16, 16'h2200, 16'h0500);
    endtask
    task automatic test_store16;
        run_op(GRP_STORE16, 16'h2300, 16'h0600);
    endtask
    task automatic test_rmw;
        run_op(GRP_RMW, 16'h2400, 16'h0700);
    endtask
    task automatic test_test;
        run_op(GRP_TEST, 16'h2500, 16'h0800);
    endtask
    task automatic test_arith16;
        run_op(GRP_ARITH16, 16'h2600, 16'h0900);
    endtask
    task automatic test_call;
        run_op(GRP_CALL, 16'h27FE, 16'h0A00);
    endtask

    // Start held through a busy instruction: ignored, then taken once idle
    task automatic test_busy_hold;
        int k;
        k = 0;
        grp <= GRP_RMW;
        req <= '{16'h3000, 16'h0100, 16'h0400, 16'h0000};
        start <= 1'b1;
        repeat (3 * BC + 3) @(posedge core_clk);
        grp <= GRP_JUMP;
        req.opcode_addr <= 16'h5000;
        #1;
        check(cycle_q === 3'h4 && busy_q === 1'b1, "restart while busy");
        while (busy_q !== 1'b0 && k < 40) begin
            @(posedge core_clk);
            k++;
        end
        start <= 1'b0;
        #1;
        check(cycle_q === 3'h1 && bus_q.address_lines === 16'h5000, "second fetch");
        repeat (3 * BC + 3) @(posedge core_clk);
        $display("test busy_hold ended");
    endtask

    task automatic test_mid_reset;
        grp <= GRP_RMW;
        start <= 1'b1;
        repeat (9) @(posedge core_clk);
        reset <= 1'b1;
        start <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        check(bus_q === {16'hFFFF, 1'b1, 8'h00, 1'b1} && cycle_q === 3'h0
            && busy_q === 1'b0 && ea_q === 16'h0000 && opcode_q === 8'h00
            && done_q === 1'b0, "state after reset");
        @(posedge core_clk);
        $display("test mid_reset ended");
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        test_jump();
        test_alu();
        test_store_acc();
        test_load16();
        test_store16();
        test_rmw();
        test_test();
        test_arith16();
        test_call();
        test_busy_hold();
        test_mid_reset();
        test_call();
        complete_run();
    end

endmodule // indexed_mode_bus_cycle_sequencer_test

bind ims_sequencer ims_seq_props #(.BUS_CLKS(BUS_CLKS)) ims_seq_props_inst (.core_clk, .reset,
    .start, .req_in, .group_in, .new_operand, .data_in, .bus_q, .rd_q, .opcode_q, .ea_q,
    .cycle_q, .busy_q, .done_q);

`default_nettype wire
